// >>> peig_top.sv
// module: endpoint interrupt generator with apb registers
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/100ps
module peig_top #(
    parameter logic [2:0] MMC = peig_pkg::MMC_RST
) (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               int_req,
    input  wire logic [4:0]         int_vector,
    input  wire logic               data_wr_pend,
    output logic                    req_valid,
    input  wire logic               req_ready,
    output peig_pkg::peig_req_t     req,
    output logic                    pending_cfg,
    output logic                    pending_mem,
    output logic                    irq
);
    import peig_pkg::*;

    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01,
        ST_HOLD = 2'b10
    } peig_state_t;

    peig_state_t      state_r;
    logic             msi_en_r;
    logic [2:0]       mme_r;
    logic [31:0]      addr_r;
    logic [15:0]      data_r;
    logic [IRQ_BITS-1:0] stat_r;
    logic [IRQ_BITS-1:0] en_r;
    logic             asserted_r;
    logic             want_r;
    logic [4:0]       vec_r;
    logic [15:0]      msi_data;
    logic [15:0]      ctl;
    logic             wr_acc;
    logic             rd_acc;
    logic             mapped;
    logic [IRQ_BITS-1:0] ev;

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    assign mapped = (paddr == ADDR_CAP_HDR) || (paddr == ADDR_MSG_ADDR)
                 || (paddr == ADDR_MSG_DATA) || (paddr == ADDR_IRQ_STAT)
                 || (paddr == ADDR_IRQ_CLR) || (paddr == ADDR_IRQ_EN)
                 || (paddr == ADDR_LEG_STAT);
    assign ctl = {8'h00, 1'b0, mme_r, MMC, msi_en_r}; // see [R05]

    // ------------------------------------------------------------
    // capability registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            msi_en_r <= 1'b0;
            mme_r    <= 3'h0;
            addr_r   <= 32'h0000_0000;
            data_r   <= 16'h0000;
        end else if (wr_acc) begin
            if (paddr == ADDR_CAP_HDR) begin
                msi_en_r <= pwdata[16+CTL_EN_BIT];
                // clamp so the enabled count never exceeds capability
                mme_r <= (pwdata[16+CTL_MME_LSB +: 3] > MMC) ? MMC
                                                             : pwdata[16+CTL_MME_LSB +: 3];
            end
            if (paddr == ADDR_MSG_ADDR) begin
                addr_r <= {pwdata[31:2], 2'b00}; // see [R14]
            end
            if (paddr == ADDR_MSG_DATA) begin
                data_r <= pwdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // apb slave: one wait-free access phase
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (rd_acc) begin
                case (paddr)
                    ADDR_CAP_HDR:  prdata <= {ctl, NEXT_PTR_RST, CAP_ID_MSI}; // see [R13]
                    ADDR_MSG_ADDR: prdata <= addr_r;
                    ADDR_MSG_DATA: prdata <= {16'h0000, data_r};
                    ADDR_IRQ_STAT: prdata <= {29'h0, stat_r};
                    ADDR_IRQ_EN:   prdata <= {29'h0, en_r};
                    ADDR_LEG_STAT: prdata <= {30'h0, asserted_r, pending_cfg};
                    default:       prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // request capture and sequencing
    // ------------------------------------------------------------
    // legacy wants the line asserted while a request is held
    always_ff @(posedge clk) begin
        if (reset) begin
            want_r <= 1'b0;
            vec_r  <= 5'h00;
        end else begin
            want_r <= int_req && !msi_en_r;
            if (int_req) begin
                vec_r <= int_vector;
            end
        end
    end

    peig_vec_mask u_mask (
        .mme    (mme_r),
        .base   (data_r),
        .vector (vec_r),
        .data   (msi_data)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r    <= ST_IDLE;
            req_valid  <= 1'b0;
            req        <= '0;
            asserted_r <= 1'b0;
            ev         <= '0;
        end else begin
            ev <= '0;
            case (state_r)
                ST_IDLE: begin
                    // msi waits for earlier posted data to drain
                    if (msi_en_r && int_req && !data_wr_pend) begin // see [R12]
                        req_valid    <= 1'b1; // see [R16]
                        req.is_msi   <= 1'b1;
                        req.msg      <= MSG_ASSERT_INTA;
                        req.addr     <= addr_r; // see [R06]
                        req.data     <= {16'h0000, msi_data};
                        req.len      <= TLP_LEN_ONE; // see [R04]
                        req.first_be <= FIRST_BE_ALL; // see [R15]
                        req.last_be  <= LAST_BE_NONE;
                        req.attr     <= ATTR_NONE;
                        state_r      <= ST_SEND;
                    end else if (!msi_en_r && (want_r != asserted_r)) begin // see [R11]
                        req_valid    <= 1'b1;
                        req.is_msi   <= 1'b0;
                        req.msg      <= want_r ? MSG_ASSERT_INTA
                                               : MSG_DEASSERT_INTA; // see [R01] [R02]
                        req.addr     <= 32'h0000_0000;
                        req.data     <= 32'h0000_0000;
                        req.len      <= 10'h000;
                        req.first_be <= 4'h0;
                        req.last_be  <= LAST_BE_NONE;
                        req.attr     <= ATTR_NONE;
                        state_r      <= ST_SEND;
                    end else if (msi_en_r && asserted_r) begin
                        // enabling msi drops a held line without a message
                        asserted_r <= 1'b0;
                    end
                end
                ST_SEND: begin
                    if (req_ready) begin
                        req_valid <= 1'b0;
                        if (req.is_msi) begin
                            ev[EV_MSI_SENT] <= 1'b1;
                            state_r         <= ST_HOLD;
                        end else begin
                            asserted_r <= (req.msg == MSG_ASSERT_INTA);
                            ev[EV_LEG_ASSERT]   <= (req.msg == MSG_ASSERT_INTA);
                            ev[EV_LEG_DEASSERT] <= (req.msg == MSG_DEASSERT_INTA);
                            state_r    <= ST_IDLE;
                        end
                    end
                end
                ST_HOLD: begin
                    // one msi per request level
                    if (!int_req) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pending bits follow the asserted line
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            pending_cfg <= 1'b0;
            pending_mem <= 1'b0;
        end else begin
            pending_cfg <= asserted_r; // see [R03]
            pending_mem <= asserted_r;
        end
    end

    // ------------------------------------------------------------
    // interrupt status, clear and enable
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            stat_r <= '0;
            en_r   <= '0;
            irq    <= 1'b0;
        end else begin
            // set wins over a clear in the same cycle
            stat_r <= (stat_r & ~((wr_acc && paddr == ADDR_IRQ_CLR) ? pwdata[IRQ_BITS-1:0]
                                                                      : '0)) | ev;
            if (wr_acc && paddr == ADDR_IRQ_EN) begin
                en_r <= pwdata[IRQ_BITS-1:0];
            end
            irq <= |(stat_r & en_r);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_msi_needs_en: assert property (@(posedge clk) disable iff (reset) // see [R16]
        (req_valid && req.is_msi) |-> msi_en_r)
        else $error("msi issued while msi disabled");
    a_no_legacy_msi: assert property (@(posedge clk) disable iff (reset) // see [R11]
        ($rose(req_valid) && !req.is_msi) |-> !$past(msi_en_r))
        else $error("legacy message while msi enabled");
    a_one_dword: assert property (@(posedge clk) disable iff (reset) // see [R04]
        (req_valid && req.is_msi) |-> (req.len == TLP_LEN_ONE))
        else $error("msi length not one dword");
    a_be_attr: assert property (@(posedge clk) disable iff (reset) // see [R15]
        (req_valid && req.is_msi) |-> (req.first_be == 4'hF && req.last_be == 4'h0
                                       && req.attr == 2'h0))
        else $error("msi byte enables or attributes wrong");
    a_addr_align: assert property (@(posedge clk) disable iff (reset) // see [R14]
        (rd_acc && paddr == ADDR_MSG_ADDR) |=> (prdata[1:0] == 2'b00))
        else $error("message address not aligned");
    a_data_bits: assert property (@(posedge clk) disable iff (reset) // see [R07]
        (req_valid && req.is_msi) |-> ((req.data[15:0] >> mme_r) == (data_r >> mme_r)))
        else $error("msi data changed too many bits");
    a_order_data: assert property (@(posedge clk) disable iff (reset) // see [R12]
        ($rose(req_valid) && req.is_msi) |-> !$past(data_wr_pend))
        else $error("msi overtook pending data");
    a_pending_set: assert property (@(posedge clk) disable iff (reset) // see [R03]
        (req_valid && req_ready && !req.is_msi && req.msg == MSG_ASSERT_INTA)
            |-> ##2 pending_cfg && pending_mem)
        else $error("pending not set after assert");
    a_cap_read: assert property (@(posedge clk) disable iff (reset) // see [R13]
        (rd_acc && paddr == ADDR_CAP_HDR) |=> (prdata[7:0] == 8'h05 && prdata[19:17] == MMC))
        else $error("capability header wrong");
    c_msi_sent: cover property (@(posedge clk) disable iff (reset)
        req_valid && req_ready && req.is_msi);
    c_leg_assert: cover property (@(posedge clk) disable iff (reset)
        req_valid && req_ready && req.msg == MSG_ASSERT_INTA && !req.is_msi);
    c_leg_deassert: cover property (@(posedge clk) disable iff (reset)
        req_valid && req_ready && req.msg == MSG_DEASSERT_INTA);
    c_irq_out: cover property (@(posedge clk) disable iff (reset) $rose(irq));
endmodule

// >>> peig_pkg.sv
// package: constants, register map and types of the endpoint interrupt generator
// Function
// [R01] legacy interrupts use only the inta line; intb, intc and intd are never sent.
// [R02] a legacy interrupt is signalled by an assert message and ended by a separate deassert message.
// [R03] each assert message also sets the pending bit in config status and in memory space.
// [R04] an enabled endpoint sends each msi as a memory write with exactly one dword of payload.
// [R05] vector counts 1 to 32 are supported and advertised in the multiple-message-capable field.
// [R06] each msi write goes to the message address and carries message data naming the vector.
// [R07] only as many low message data bits as the allocated vector count allows may change.
// [R08] host software enables msi and multiple vectors through the control register.
// [R09] host software writes a multiple-message-enable no greater than the capable value.
// [R10] host software writes data and address before it sets the msi enable bit.
// [R11] with msi enabled, msi writes are the only delivery method and no legacy messages go out.
// [R12] an msi write is sent in order behind earlier data writes.
// [R13] capability dword 0 holds id 05h in bits 7..0, next pointer in 15..8, control in 31..16.
// [R14] the two low bits of the message address always read as zero.
// [R15] each msi request has length 01h, first be 1111b, last be 0000b, no-snoop and ro clear.
// [R16] no msi write is issued while msi enable is clear; requests use the legacy path.
package peig_pkg;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CAP_HDR   = 8'h00;
    localparam logic [7:0] ADDR_MSG_ADDR  = 8'h04;
    localparam logic [7:0] ADDR_MSG_DATA  = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_CLR   = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'h14;
    localparam logic [7:0] ADDR_LEG_STAT  = 8'h18;
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CAP_ID_MSI     = 8'h05;
    localparam logic [7:0] NEXT_PTR_RST   = 8'h00;
    localparam int         CTL_EN_BIT     = 0;
    localparam int         CTL_MMC_LSB    = 1;
    localparam int         CTL_MME_LSB    = 4;
    localparam logic [2:0] MMC_RST        = 3'h5;
    localparam logic [9:0] TLP_LEN_ONE    = 10'h001;
    localparam logic [3:0] FIRST_BE_ALL   = 4'hF;
    localparam logic [3:0] LAST_BE_NONE   = 4'h0;
    localparam logic [1:0] ATTR_NONE      = 2'h0;
    localparam int         IRQ_BITS       = 3;
    localparam int         EV_MSI_SENT    = 0;
    localparam int         EV_LEG_ASSERT  = 1;
    localparam int         EV_LEG_DEASSERT = 2;

    typedef enum logic [1:0] {
        MSG_ASSERT_INTA   = 2'b00,
        MSG_DEASSERT_INTA = 2'b01
    } peig_msg_t;

    // one outgoing request toward the transaction layer
    typedef struct packed {
        logic        is_msi;
        peig_msg_t   msg;
        logic [31:0] addr;
        logic [31:0] data;
        logic [9:0]  len;
        logic [3:0]  first_be;
        logic [3:0]  last_be;
        logic [1:0]  attr;
    } peig_req_t;
endpackage

// >>> peig_vec_mask.sv
// module: merges the user vector into the message data low bits
`timescale 1ns/100ps
module peig_vec_mask (
    input  wire logic [2:0]  mme,
    input  wire logic [15:0] base,
    input  wire logic [4:0]  vector,
    output logic      [15:0] data
);
    import peig_pkg::*;
    logic [15:0] mask;
    always_comb begin
        // mme of n allows 2**n vectors, so n low bits may change, at most 5 bits for mme 5 to 7
        case (mme)
            3'h0:    mask = 16'h0000;
            3'h1:    mask = 16'h0001;
            3'h2:    mask = 16'h0003;
            3'h3:    mask = 16'h0007;
            3'h4:    mask = 16'h000F;
            default: mask = 16'h001F;
        endcase
        data = (base & ~mask) | ({11'h000, vector} & mask); // see [R07]
    end
endmodule

// >>> peig_root_model.sv
// upstream root port model that accepts interrupt requests with an adjustable stall
`timescale 1ns/100ps
module peig_root_model (
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          req_valid,
    input  peig_pkg::peig_req_t req,
    input  wire logic [3:0]    stall,
    output logic               req_ready,
    output logic [7:0]         acc_cnt,
    output peig_pkg::peig_req_t acc_req
);
    import peig_pkg::*;
    logic [3:0] wait_r;

    // ------------------------------------------------------------
    // accept path
    // ------------------------------------------------------------
    // ready only rises after stall cycles of a waiting request
    always_ff @(posedge clk) begin
        if (reset) begin
            req_ready <= 1'b0;
            wait_r    <= 4'h0;
            acc_cnt   <= 8'h00;
            acc_req   <= '0;
        end else if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            wait_r    <= 4'h0;
            acc_cnt   <= acc_cnt + 8'h01;
            acc_req   <= req;
        end else if (req_valid) begin
            if (wait_r >= stall) begin
                req_ready <= 1'b1;
            end else begin
                wait_r <= wait_r + 4'h1;
            end
        end
    end
endmodule

// >>> test_pcie_endpoint_interrupt_gen.sv
// testbench of the endpoint interrupt generator
`timescale 1ns/100ps
module test_pcie_endpoint_interrupt_gen;
    import peig_pkg::*;
    localparam logic [2:0] MMC_TB = 3'h3;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr, err;
    logic        int_req, data_wr_pend, req_valid, req_ready, pending_cfg, pending_mem, irq;
    logic [7:0]  paddr, acc_cnt;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0]  int_vector;
    logic [3:0]  stall;
    peig_req_t   req, acc_req;
    int          miscompares, checked;

    peig_top #(.MMC(MMC_TB)) DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .int_req(int_req), .int_vector(int_vector),
        .data_wr_pend(data_wr_pend), .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .pending_cfg(pending_cfg), .pending_mem(pending_mem), .irq(irq));
    peig_root_model root (.clk(clk), .reset(reset), .req_valid(req_valid), .req(req),
        .stall(stall), .req_ready(req_ready), .acc_cnt(acc_cnt), .acc_req(acc_req));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task wait_acc(input logic [7:0] n);
        int k;
        k = 0;
        while (acc_cnt !== n && k < 40) begin
            @(negedge clk);
            k++;
        end
        chk("request count", 32'(n), 32'(acc_cnt));
    endtask

    task finish_test;
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        finish_test;
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        reset        = 1'b1;
        psel         = 1'b0;
        penable      = 1'b0;
        pwrite       = 1'b0;
        paddr        = 8'h00;
        pwdata       = 32'h0;
        int_req      = 1'b0;
        int_vector   = 5'h00;
        data_wr_pend = 1'b0;
        stall        = 4'h0;
        miscompares  = 0;
        checked      = 0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        apb(1'b0, ADDR_CAP_HDR, 32'h0);
        chk("cap dword", {12'h0, MMC_TB, 1'b0, NEXT_PTR_RST, CAP_ID_MSI}, rd);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, ADDR_IRQ_STAT, 32'h7);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk("status read only", 32'h0, rd);
        $display("test registers done");
        int_vector <= 5'h03;
        int_req <= 1'b1;
        wait_acc(8'h01);
        chk("legacy kind", 32'h0, 32'(acc_req.is_msi));
        chk("assert msg", 32'(MSG_ASSERT_INTA), 32'(acc_req.msg));
        repeat (4) @(posedge clk);
        chk("pending cfg", 32'h1, 32'(pending_cfg));
        chk("pending mem", 32'h1, 32'(pending_mem));
        apb(1'b0, ADDR_LEG_STAT, 32'h0);
        chk("legacy status", 32'h3, rd);
        chk("irq masked", 32'h0, 32'(irq));
        apb(1'b1, ADDR_IRQ_EN, 32'h7);
        repeat (2) @(posedge clk);
        chk("irq enabled", 32'h1, 32'(irq));
        int_req <= 1'b0;
        wait_acc(8'h02);
        chk("deassert msg", 32'(MSG_DEASSERT_INTA), 32'(acc_req.msg));
        repeat (4) @(posedge clk);
        chk("pending cleared", 32'h0, 32'(pending_cfg));
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk("legacy events", 32'h6, rd);
        apb(1'b1, ADDR_IRQ_CLR, 32'h6);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk("status cleared", 32'h0, rd);
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h0, 32'(irq));
        $display("test legacy done");
        apb(1'b0, ADDR_CAP_HDR, 32'h0);
        apb(1'b1, ADDR_CAP_HDR, {9'h0, rd[19:17], 4'h0, 16'h0});
        apb(1'b1, ADDR_MSG_ADDR, 32'h1234567F);
        apb(1'b1, ADDR_MSG_DATA, 32'h0000ABC0);
        apb(1'b0, ADDR_MSG_ADDR, 32'h0);
        chk("address low bits", 32'h1234567C, rd);
        apb(1'b0, ADDR_MSG_DATA, 32'h0);
        chk("message data", 32'h0000ABC0, rd);
        apb(1'b1, ADDR_CAP_HDR, {9'h0, MMC_TB, 3'h0, 1'b1, 16'h0});
        apb(1'b0, ADDR_CAP_HDR, 32'h0);
        chk("control", {9'h0, MMC_TB, MMC_TB, 1'b1, NEXT_PTR_RST, CAP_ID_MSI}, rd);
        stall <= 4'h3;
        data_wr_pend <= 1'b1;
        int_vector <= 5'h1E;
        int_req <= 1'b1;
        repeat (6) @(posedge clk);
        chk("held behind data", 32'h2, 32'(acc_cnt));
        data_wr_pend <= 1'b0;
        wait_acc(8'h03);
        chk("msi kind", 32'h1, 32'(acc_req.is_msi));
        chk("msi address", 32'h1234567C, acc_req.addr);
        chk("msi data", 32'h0000ABC6, acc_req.data);
        chk("msi length", 32'(TLP_LEN_ONE), 32'(acc_req.len));
        chk("first be", 32'(FIRST_BE_ALL), 32'(acc_req.first_be));
        chk("last be", 32'(LAST_BE_NONE), 32'(acc_req.last_be));
        chk("attr", 32'(ATTR_NONE), 32'(acc_req.attr));
        repeat (6) @(posedge clk);
        chk("one write per request", 32'h3, 32'(acc_cnt));
        int_req <= 1'b0;
        repeat (8) @(posedge clk);
        chk("no legacy in msi mode", 32'h3, 32'(acc_cnt));
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk("msi event", 32'h1, rd);
        chk("irq msi", 32'h1, 32'(irq));
        $display("test msi done");
        finish_test;
    end
endmodule
